// ### design/gic_params.svh
// register offsets, field positions and reset values of the init and reset configuration bank
`ifndef GIC_PARAMS_SVH
`define GIC_PARAMS_SVH
`define GIC_OFF_DEV_CTL        16'h0000
`define GIC_OFF_DEV_STATUS     16'h0008
`define GIC_OFF_GLOBAL_RST     16'h0010
`define GIC_OFF_MASK_READ      16'h00D0
`define GIC_OFF_MASK_SET       16'h00D4
`define GIC_OFF_MASK_CLEAR     16'h00D8
`define GIC_OFF_RXO_COUNT      16'h4124
`define GIC_DEV_CTL_RESET      32'h0010_0800
`define GIC_CTL_DUPLEX_BIT     0
`define GIC_CTL_LINK_HOLD_BIT  3
`define GIC_CTL_INV_LOS_BIT    7
`define GIC_CTL_SPD_LSB        8
`define GIC_CTL_FRCSPD_BIT     11
`define GIC_CTL_FRCDPX_BIT     12
`define GIC_ST_DUPLEX_BIT      0
`define GIC_ST_TEN_BIT_BIT     5
`define GIC_ST_SPD_LSB         6
`define GIC_ST_READY_BIT       9
`define GIC_ST_AN_BIT          10
`define GIC_MASK_RESET         32'h0000_0000
`define GIC_COUNT_RESET        32'h0000_0000
`define GIC_GRST_KEY_BIT       0
`endif

// ### design/gic_pkg.sv
// types shared by the init and reset configuration bank
package gic_pkg;
	// register port request
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} gic_req_type;
	// nonvolatile straps caught after reset
	typedef struct packed {
		logic        an_at_reset;
		logic        link_hold_override;
		logic        link_hold_value;
		logic        duplex_override;
		logic        duplex_value;
	} gic_nvm_type;
	// link control phase
	typedef enum logic [2:0] {
		GIC_ST_IDLE  = 3'b001,
		GIC_ST_INIT  = 3'b010,
		GIC_ST_READY = 3'b100
	} gic_state_type;
endpackage : gic_pkg

// ### design/gic_init_cfg.sv
// init, global reset and configuration register bank of the ethernet controller
// Notes on behaviour
// - 32-bit overrun interrupt count, clears on read
// - not functional until driver finishes setup
// - auto-negotiation at reset only if nonvolatile enabled
// - mask clear write disables interrupt causes
// - mask set write enables matching causes
// - global reset returns to known state
// - status shows interface kind for software
// - auto-negotiated duplex set by hardware, shown
// - speed from phy, mac or forced; no mac speed detection here, phy or forced only
// - ten-bit link reset defaults one; falling starts
// - control resets to default except nonvolatile overrides
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "gic_params.svh"
module gic_init_cfg (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_srst,
	input  wire gic_pkg::gic_req_type i_req,
	output logic [31:0]               o_rdata,
	input  wire gic_pkg::gic_nvm_type i_nvm,
	input  wire logic                 i_ten_bit_interface,
	input  wire logic                 i_phy_full_duplex,
	input  wire logic [1:0]           i_phy_speed,
	input  wire logic                 i_phy_an_done,
	input  wire logic                 i_rx_overrun_irq,
	output logic [31:0]               o_int_mask,
	output logic                      o_an_start,
	output logic                      o_dev_ready,
	output logic                      o_full_duplex,
	output logic [1:0]                o_link_speed
);
	import gic_pkg::*;

	logic          grst_ff;
	logic [31:0]   ctl_ff;
	logic [31:0]   mask_ff;
	logic [31:0]   cnt_ff;
	logic [31:0]   rdata_ff;
	logic          an_ff;
	logic          started_ff;
	logic          hold_prev_ff;
	logic          duplex_ff;
	logic [1:0]    spd_ff;
	logic          ten_s1_ff;
	logic          ten_ff;
	logic [3:0]    phy_s1_ff;
	logic [3:0]    phy_ff;
	logic          ovr_s1_ff;
	logic          ovr_ff;
	logic          ovr_prev_ff;
	gic_state_type state_ff;
	gic_state_type nxt_state;
	logic          wr_ctl;
	logic          rd_cnt;
	logic          ovr_evt;
	logic          soft_rst;
	logic          any_rst;
	logic [31:0]   ctl_dflt;
	logic [31:0]   status;

	// two-stage synchronisers for pin inputs
	// only the second stage is ever read, so a metastable first stage never reaches logic
	// pin levels are slow straps and status, so a plain two-flop chain per bit is enough
	always_ff @(posedge i_clk_sys) begin
		ten_s1_ff <= i_ten_bit_interface;
		ten_ff    <= ten_s1_ff;
		phy_s1_ff <= {i_phy_an_done, i_phy_full_duplex, i_phy_speed};
		phy_ff    <= phy_s1_ff;
		ovr_s1_ff <= i_rx_overrun_irq;
		ovr_ff    <= ovr_s1_ff;
	end

	// decode
	assign wr_ctl   = i_req.wr && (i_req.addr == `GIC_OFF_DEV_CTL);
	assign rd_cnt   = i_req.rd && (i_req.addr == `GIC_OFF_RXO_COUNT);
	assign soft_rst = i_req.wr && (i_req.addr == `GIC_OFF_GLOBAL_RST) && i_req.wdata[`GIC_GRST_KEY_BIT];
	assign any_rst  = i_srst || grst_ff;
	assign ovr_evt  = ovr_ff && !ovr_prev_ff;

	// control default with nonvolatile overrides
	always_comb begin
		ctl_dflt = `GIC_DEV_CTL_RESET;
		ctl_dflt[`GIC_CTL_LINK_HOLD_BIT] = i_nvm.link_hold_override ? i_nvm.link_hold_value : 1'b1;
		if (i_nvm.duplex_override) begin
			ctl_dflt[`GIC_CTL_DUPLEX_BIT] = i_nvm.duplex_value;
		end
	end

	// global reset pulse, held one cycle so writes in it are dropped
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			grst_ff <= 1'b0;
		end else begin
			grst_ff <= soft_rst;
		end
	end

	// device control register
	always_ff @(posedge i_clk_sys) begin
		if (any_rst) begin
			ctl_ff <= `GIC_DEV_CTL_RESET;
		end else if (!started_ff) begin
			ctl_ff <= ctl_dflt;
		end else if (wr_ctl) begin
			ctl_ff <= i_req.wdata;
		end
	end

	// interrupt mask
	always_ff @(posedge i_clk_sys) begin
		if (any_rst) begin
			mask_ff <= `GIC_MASK_RESET;
		end else if (i_req.wr && i_req.addr == `GIC_OFF_MASK_CLEAR) begin
			mask_ff <= mask_ff & ~i_req.wdata;
		end else if (i_req.wr && i_req.addr == `GIC_OFF_MASK_SET) begin
			mask_ff <= mask_ff | i_req.wdata;
		end
	end

	// overrun counter, clear on read, event in the read cycle counts as one
	always_ff @(posedge i_clk_sys) begin
		ovr_prev_ff <= i_srst ? 1'b0 : ovr_ff;
		if (any_rst) begin
			cnt_ff <= `GIC_COUNT_RESET;
		end else if (rd_cnt) begin
			cnt_ff <= {31'h0, ovr_evt};
		end else if (ovr_evt) begin
			cnt_ff <= cnt_ff + 32'h1;
		end
	end

	// first cycle after reset loads straps; track link reset edge
	always_ff @(posedge i_clk_sys) begin
		if (any_rst) begin
			started_ff   <= 1'b0;
			hold_prev_ff <= 1'b1; // matches the held default, so no false release edge
		end else begin
			started_ff   <= 1'b1;
			hold_prev_ff <= ctl_ff[`GIC_CTL_LINK_HOLD_BIT];
		end
	end

	// auto-negotiation start pulse
	always_ff @(posedge i_clk_sys) begin
		if (any_rst) begin
			an_ff <= 1'b0;
		end else if (!started_ff) begin
			an_ff <= i_nvm.an_at_reset && !(ten_ff && ctl_dflt[`GIC_CTL_LINK_HOLD_BIT]);
		end else begin
			an_ff <= ten_ff && hold_prev_ff && !ctl_ff[`GIC_CTL_LINK_HOLD_BIT];
		end
	end

	// readiness phase: idle for the first two cycles after reset, then init until software writes control
	always_comb begin
		case (state_ff)
			GIC_ST_IDLE:  nxt_state = started_ff ? GIC_ST_INIT : GIC_ST_IDLE;
			GIC_ST_INIT:  nxt_state = wr_ctl ? GIC_ST_READY : GIC_ST_INIT;
			GIC_ST_READY: nxt_state = GIC_ST_READY;
			default:      nxt_state = GIC_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (any_rst) begin
			state_ff <= GIC_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// resolved duplex and speed
	// speed keeps its last resolved value while negotiation is not done and nothing is forced
	always_ff @(posedge i_clk_sys) begin
		if (any_rst) begin
			duplex_ff <= 1'b0;
			spd_ff    <= 2'h0;
		end else begin
			if (ctl_ff[`GIC_CTL_FRCDPX_BIT] || !phy_ff[3]) begin
				duplex_ff <= ctl_ff[`GIC_CTL_DUPLEX_BIT];
			end else begin
				duplex_ff <= phy_ff[2];
			end
			if (ctl_ff[`GIC_CTL_FRCSPD_BIT]) begin
				spd_ff <= ctl_ff[`GIC_CTL_SPD_LSB +: 2];
			end else if (phy_ff[3]) begin
				spd_ff <= phy_ff[1:0];
			end
		end
	end

	// status word
	always_comb begin
		status = 32'h0;
		status[`GIC_ST_DUPLEX_BIT]      = duplex_ff;
		status[`GIC_ST_TEN_BIT_BIT]     = ten_ff;
		status[`GIC_ST_SPD_LSB +: 2]    = spd_ff;
		status[`GIC_ST_READY_BIT]       = (state_ff == GIC_ST_READY);
		status[`GIC_ST_AN_BIT]          = phy_ff[3];
	end

	// read data one cycle after strobe
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			rdata_ff <= 32'h0;
		end else if (i_req.rd) begin
			case (i_req.addr)
				`GIC_OFF_DEV_CTL:    rdata_ff <= ctl_ff;
				`GIC_OFF_DEV_STATUS: rdata_ff <= status;
				`GIC_OFF_MASK_READ:  rdata_ff <= mask_ff;
				`GIC_OFF_RXO_COUNT:  rdata_ff <= cnt_ff;
				default:             rdata_ff <= 32'h0;
			endcase
		end else begin
			rdata_ff <= 32'h0;
		end
	end

	assign o_rdata       = rdata_ff;
	assign o_int_mask    = mask_ff;
	assign o_an_start    = an_ff;
	assign o_dev_ready   = (state_ff == GIC_ST_READY);
	assign o_full_duplex = duplex_ff;
	assign o_link_speed  = spd_ff;

	// checks: each guards one rule of the list at the head of this file, except a_rdata_idle, which guards the strobed port

	// a mask clear write leaves none of its bits enabled
	a_mask_clear: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(i_req.wr && i_req.addr == `GIC_OFF_MASK_CLEAR && !any_rst) |=> ((mask_ff & $past(i_req.wdata)) == 32'h0))
		else $error("mask clear left bits set");

	// a mask set write enables all of its bits
	a_mask_set: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(i_req.wr && i_req.addr == `GIC_OFF_MASK_SET && !any_rst) |=> ((mask_ff & $past(i_req.wdata)) == $past(i_req.wdata)))
		else $error("mask set missed bits");

	// without a write the mask does not move
	a_mask_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(!i_req.wr && !any_rst) |=> $stable(o_int_mask))
		else $error("mask moved without write");

	// a counter read leaves zero, or one when an event falls in the read cycle
	a_count_clear: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(rd_cnt && !any_rst) |=> (cnt_ff <= 32'h1))
		else $error("counter not cleared on read");

	// each overrun edge adds exactly one
	a_count_inc: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(ovr_evt && !rd_cnt && !any_rst) |=> (cnt_ff == $past(cnt_ff) + 32'h1))
		else $error("overrun not counted");

	// no event and no read keeps the count
	a_count_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(!ovr_evt && !rd_cnt && !any_rst) |=> $stable(cnt_ff))
		else $error("counter moved without event");

	// the read returns the count as it stood before the clear
	a_count_read: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		rd_cnt |=> (o_rdata == $past(cnt_ff)))
		else $error("counter read data wrong");

	// read data are zero outside the cycle after a read
	a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		!i_req.rd |=> (o_rdata == 32'h0))
		else $error("read data without read");

	// global reset brings masks, counter and readiness back
	a_grst_known: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		soft_rst |=> ##1 (mask_ff == 32'h0 && cnt_ff == 32'h0 && !o_dev_ready))
		else $error("global reset left state");

	// the internal reset cycle reloads the control register
	a_grst_ctl: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		grst_ff |=> (ctl_ff == `GIC_DEV_CTL_RESET))
		else $error("global reset left control");

	// the internal reset cycle restarts the setup phase
	a_grst_state: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		grst_ff |=> (state_ff == GIC_ST_IDLE && !started_ff))
		else $error("global reset left phase");

	// the first cycle after reset takes the default with overrides
	a_ctl_default: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(!started_ff && !any_rst) |=> (ctl_ff == $past(ctl_dflt)))
		else $error("control default not loaded");

	// a control write lands once setup is open
	a_ctl_write: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(started_ff && !any_rst && wr_ctl) |=> (ctl_ff == $past(i_req.wdata)))
		else $error("control write lost");

	// not ready until software writes control
	a_not_ready: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(!o_dev_ready && !wr_ctl) |=> !o_dev_ready)
		else $error("ready without setup");

	// the setup write makes the device ready
	a_ready_rise: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(state_ff == GIC_ST_INIT && wr_ctl && !any_rst) |=> o_dev_ready)
		else $error("setup write ignored");

	// ready stays until a reset
	a_ready_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(o_dev_ready && !any_rst) |=> o_dev_ready)
		else $error("ready dropped");

	// no negotiation at reset unless the straps enable it
	a_an_gate: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(!started_ff && !any_rst && !i_nvm.an_at_reset) |=> !o_an_start)
		else $error("negotiation without enable");

	// releasing the link hold in ten-bit mode starts negotiation
	a_hold_release: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(started_ff && !any_rst && ten_ff && hold_prev_ff && !ctl_ff[`GIC_CTL_LINK_HOLD_BIT]) |=> o_an_start)
		else $error("link reset release ignored");

	// forced speed is what the status shows
	a_speed_forced: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(ctl_ff[`GIC_CTL_FRCSPD_BIT] && !any_rst) |=> (o_link_speed == $past(ctl_ff[`GIC_CTL_SPD_LSB +: 2])))
		else $error("forced speed not shown");

	// negotiated speed follows the phy when nothing is forced
	a_speed_auto: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(!ctl_ff[`GIC_CTL_FRCSPD_BIT] && phy_ff[3] && !any_rst) |=> (o_link_speed == $past(phy_ff[1:0])))
		else $error("negotiated speed not shown");

	// negotiated duplex follows the phy when nothing is forced
	a_duplex_auto: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(!ctl_ff[`GIC_CTL_FRCDPX_BIT] && phy_ff[3] && !any_rst) |=> (o_full_duplex == $past(phy_ff[2])))
		else $error("negotiated duplex not shown");

	// main scenarios
	c_ready: cover property (@(posedge i_clk_sys) $rose(o_dev_ready));
	c_an: cover property (@(posedge i_clk_sys) o_an_start);
	c_rc: cover property (@(posedge i_clk_sys) rd_cnt && cnt_ff != 32'h0);
	c_grst: cover property (@(posedge i_clk_sys) soft_rst);
	c_forced: cover property (@(posedge i_clk_sys) ctl_ff[`GIC_CTL_FRCSPD_BIT] && ctl_ff[`GIC_CTL_FRCDPX_BIT]);
endmodule : gic_init_cfg

// ### test/testbench.sv
// self-checking bench of the init and reset configuration bank
`timescale 1ns/1ps
`include "gic_params.svh"
module testbench;
	import gic_pkg::*;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic        i_clk_sys;
	logic        i_srst;
	gic_req_type req;
	gic_nvm_type nvm;
	logic        ten_bit, phy_duplex, pan, ovr;
	logic [1:0]  pspd;
	logic [31:0] o_rdata, o_int_mask;
	logic        o_an_start, o_dev_ready, o_full_duplex;
	logic [1:0]  o_link_speed;
	int          failures, checked, an_cnt, base;

	gic_init_cfg u_gic_init_cfg (
		.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_req(req), .o_rdata(o_rdata), .i_nvm(nvm),
		.i_ten_bit_interface(ten_bit), .i_phy_full_duplex(phy_duplex), .i_phy_speed(pspd), .i_phy_an_done(pan),
		.i_rx_overrun_irq(ovr), .o_int_mask(o_int_mask), .o_an_start(o_an_start),
		.o_dev_ready(o_dev_ready), .o_full_duplex(o_full_duplex), .o_link_speed(o_link_speed)
	);

	// counts start pulses seen on the link side
	always @(posedge i_clk_sys) begin
		if (o_an_start === 1'b1) an_cnt++;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : idle

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk_sys);
		req.wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] exp, input string name);
		@(posedge i_clk_sys);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk_sys);
		req.rd <= 1'b0;
		#1 check(name, o_rdata & m, exp);
	endtask : rd

	// reset for 20 cycles, then count start pulses
	task automatic do_rst(input logic an, input logic [31:0] exp);
		@(posedge i_clk_sys);
		nvm <= '{an_at_reset: an, default: 1'b0};
		i_srst <= 1'b1;
		repeat (20) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		base = an_cnt;
		idle(8);
		check("an_start at reset", an_cnt - base, exp);
	endtask : do_rst

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	// watchdog far beyond the about 123 cycles the tests need
	initial begin
		repeat (4000) @(posedge i_clk_sys);
		failures++;
		stop_test;
	end

	initial begin
		req = '0;
		nvm = '0;
		ten_bit = 1'b0;
		phy_duplex = 1'b1;
		pan = 1'b1;
		ovr = 1'b0;
		pspd = 2'b10;
		failures = 0;
		checked = 0;
		an_cnt = 0;
		do_rst(1'b1, 32'h1);
		check("mask", o_int_mask, 32'h0);
		check("ready", {31'h0, o_dev_ready}, 32'h0);
		rd(`GIC_OFF_DEV_CTL, ALL, 32'h0010_0808, "ctl");
		rd(`GIC_OFF_RXO_COUNT, ALL, 32'h0, "count");
		rd(16'h0100, ALL, 32'h0, "unmapped");
		// three separate overrun events
		repeat (3) begin
			@(posedge i_clk_sys) ovr <= 1'b1;
			repeat (2) @(posedge i_clk_sys);
			ovr <= 1'b0;
			repeat (2) @(posedge i_clk_sys);
		end
		idle(4);
		rd(`GIC_OFF_RXO_COUNT, ALL, 32'h3, "count");
		rd(`GIC_OFF_RXO_COUNT, ALL, 32'h0, "count cleared");
		wr(`GIC_OFF_MASK_SET, 32'h0000_00FF);
		idle(1);
		check("mask set", o_int_mask, 32'h0000_00FF);
		wr(`GIC_OFF_MASK_CLEAR, 32'h0000_000F);
		idle(1);
		check("mask clear", o_int_mask, 32'h0000_00F0);
		rd(`GIC_OFF_MASK_READ, ALL, 32'h0000_00F0, "mask read");
		// ten-bit mode: dropping the link hold starts negotiation
		@(posedge i_clk_sys) ten_bit <= 1'b1;
		idle(4);
		base = an_cnt;
		wr(`GIC_OFF_DEV_CTL, 32'h0);
		idle(4);
		check("an_start link hold", an_cnt - base, 32'h1);
		check("ready", {31'h0, o_dev_ready}, 32'h1);
		check("speed", {30'h0, o_link_speed}, 32'h2);
		check("duplex", {31'h0, o_full_duplex}, 32'h1);
		rd(`GIC_OFF_DEV_STATUS, 32'h0000_06E1, 32'h0000_06A1, "status");
		// forced speed 1 and forced half duplex
		wr(`GIC_OFF_DEV_CTL, 32'h0000_1900);
		idle(2);
		check("forced speed", {30'h0, o_link_speed}, 32'h1);
		check("forced duplex", {31'h0, o_full_duplex}, 32'h0);
		wr(`GIC_OFF_MASK_SET, 32'h0000_00FF);
		wr(`GIC_OFF_GLOBAL_RST, 32'h0000_0001);
		idle(2);
		check("mask after global", o_int_mask, 32'h0);
		wr(`GIC_OFF_MASK_CLEAR, ALL);
		idle(1);
		check("mask after remask", o_int_mask, 32'h0);
		// flow control, arbitration, gap and mac-phy words live outside this bank
		rd(`GIC_OFF_DEV_CTL, ALL, 32'h0010_0808, "ctl after global");
		do_rst(1'b0, 32'h0);
		stop_test;
	end
endmodule : testbench
